// File: common/txcfg_pkg.sv
// Constants, register map and field layout for the transmitter configuration bank.
// Assumes a 32-bit Avalon-MM slave port; printed register offsets are word indices.
// Functional notes
// - Modulator bit 15 set selects linear transient, clear selects shaped transient.
// - Phase reversal at Tari 25us: full-depth bit picks ASK or PR delimiter shape.
// - Tari 12.5us or 6.25us always uses ASK delimiter, full-depth bit ignored.
// - Without phase reversal or full depth, depth field is ASK depth, 3F full.
// - With phase reversal or full depth, depth field sets delimiter 9.6 to 15.9us.
// - Ramp field: 00 from Tari, 01 100us, 10 200us, 11 400us.
// - Full-depth bit 5 forces 100 percent depth; depth field becomes delimiter length.
// - Bits 4:3 coarse attenuation: 00 nominal, 01 minus 6dB, 10 minus 12dB.
// - Bits 2:0 fine attenuation, each step lowers output by 1dB.
// - Reset or chip enable low presets modulator word to 20 3F 00.
// - Bits 22:20 select synthesizer reference frequency from 500kHz down to 25kHz.
// - Main divider N equals B times 32 plus A times 33.
// - Reset or chip enable low presets main divider word to 40 D8 4F.
// - Auxiliary word holds its own B and A with the same relation.
// - Auxiliary bit 21 selects external RF source, else internal oscillator.
// - Auxiliary bit 22 selects direct oscillator path, else normal path.
// - Auxiliary bit 20 enables divider and prescaler.
// - Reset or chip enable low presets auxiliary divider word to 01 18 46.
// - Modulator bits 17:16 set ASK transient rate: Tari, skip 2, 4, 8.
package txcfg_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_MOD_CTRL = 8'h15;
	localparam logic [7:0] IDX_SYNTH_MAIN = 8'h16;
	localparam logic [7:0] IDX_SYNTH_AUX = 8'h17;
	localparam logic [7:0] IDX_DAC = 8'h18;
	localparam logic [7:0] IDX_TARI = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h21;
	// Reset values
	localparam logic [23:0] RST_MOD_CTRL = 24'h203F00;
	localparam logic [23:0] RST_SYNTH_MAIN = 24'h40D84F;
	localparam logic [23:0] RST_SYNTH_AUX = 24'h011846;
	localparam logic [7:0] RST_DAC = 8'h00;
	localparam logic [1:0] RST_TARI = 2'h0;
	// Modulator field positions
	localparam int MOD_LIN = 15;
	localparam int MOD_PR = 14;
	localparam int MOD_DEP_LSB = 8;
	localparam int MOD_RAMP_LSB = 6;
	localparam int MOD_FULL = 5;
	localparam int MOD_COARSE_LSB = 3;
	localparam int MOD_ASKRATE_LSB = 16;
	// Divider field positions
	localparam int DIV_BIAS = 23;
	localparam int DIV_REF_LSB = 20;
	localparam int DIV_B_LSB = 10;
	localparam int AUX_DIRECT = 22;
	localparam int AUX_EXT = 21;
	localparam int AUX_PRESC = 20;
	localparam int PRESC_LO = 32;
	localparam int PRESC_HI = 33;
	// Tari codes and delimiter figures in tenths of a microsecond
	localparam logic [1:0] TARI_25 = 2'h0;
	localparam logic [1:0] TARI_12P5 = 2'h1;
	localparam logic [1:0] TARI_6P25 = 2'h2;
	localparam int DELIM_MIN_TENTHS = 96;
	localparam logic [5:0] DEPTH_FULL = 6'h3F;
	// Ramp times in microseconds, code 0 means Tari derived
	localparam int RAMP_US_1 = 100;
	localparam int RAMP_US_2 = 200;
	localparam int RAMP_US_3 = 400;
	localparam int CLK_MHZ = 125;
	localparam int RAMP_CYC_1 = RAMP_US_1 * CLK_MHZ;
	localparam int RAMP_CYC_2 = RAMP_US_2 * CLK_MHZ;
	localparam int RAMP_CYC_3 = RAMP_US_3 * CLK_MHZ;
	// Reference frequency per select code, in kHz
	function automatic logic [9:0] ref_khz(input logic [2:0] sel);
		case (sel)
			3'h0: ref_khz = 10'd500;
			3'h1: ref_khz = 10'd250;
			3'h4: ref_khz = 10'd200;
			3'h2: ref_khz = 10'd125;
			3'h5: ref_khz = 10'd100;
			3'h6: ref_khz = 10'd50;
			3'h7: ref_khz = 10'd25;
			default: ref_khz = 10'd0;
		endcase
	endfunction
	typedef enum logic [1:0] {SHAPE_SHAPED, SHAPE_LINEAR, SHAPE_ASK_DELIM, SHAPE_PR_DELIM} shape_t;
endpackage

// File: rtl/dual_mod_divider.sv
`timescale 1ns/1ps
// Divider ratio calculator for one synthesizer word.
// Assumes a stable word from the register bank; result is registered.
module dual_mod_divider
	import txcfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [23:0] word,
	output logic [15:0] ratio
);
	logic [15:0] ratio_nxt;
	always_comb begin
		ratio_nxt = 16'(word[19:10] * PRESC_LO) + 16'(word[9:0] * PRESC_HI);
	end
	// Registered so the output stands as a flip-flop value
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ratio <= 16'h0000;
		end else begin
			ratio <= ratio_nxt;
		end
	end
	// registered ratio, skipped on the first edge out of reset
	a_ratio_sum: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) |-> ratio == 16'($past(word[19:10]) * PRESC_LO) + 16'($past(word[9:0]) * PRESC_HI))
		else $error("divider ratio mismatch");
endmodule

// File: rtl/tx_synth_cfg_regs.sv
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
// Modulator and synthesizer configuration bank with Avalon-MM slave.
// Assumes rstn and chip_en are asynchronous pins; one 125 MHz clock.
module tx_synth_cfg_regs
	import txcfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic chip_en,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	output logic linear_transient,
	output logic phase_reversal_enable,
	output logic full_depth_ask,
	output logic [1:0] delim_shape,
	output logic [5:0] ask_depth,
	output logic [7:0] delim_tenths_us,
	output logic [1:0] ask_rate,
	output logic [1:0] ramp_sel,
	output logic [15:0] ramp_cycles,
	output logic [1:0] coarse_atten,
	output logic [2:0] fine_atten_db,
	output logic [9:0] ref_freq_khz,
	output logic [2:0] reference_divider_sel,
	output logic [15:0] main_ratio,
	output logic [15:0] aux_ratio,
	output logic ext_rf_sel,
	output logic osc_direct,
	output logic presc_enable,
	output logic amp_bias_double,
	output logic amp_bias_quad,
	output logic [7:0] dac_value
);
	logic rst_s1, rst_n;
	logic en_s1, en_s2, en_s3, en_stable_r;
	logic [23:0] mod_ctrl_r, synth_main_r, synth_aux_r;
	logic [7:0] dac_r;
	logic [1:0] tari_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic [1:0] resp_r;
	logic wr_hit, preset;

	// Reset released through two flip-flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Chip enable from a pin: three stages, change accepted when last two agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
			en_s3 <= 1'b0;
			en_stable_r <= 1'b0;
		end else begin
			en_s1 <= chip_en;
			en_s2 <= en_s1;
			en_s3 <= en_s2;
			if (en_s2 == en_s3) begin
				en_stable_r <= en_s3;
			end
		end
	end
	assign preset = !en_stable_r;

	// Merge byte lanes of a write into a 24-bit word
	function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [23:0] m;
		m = old;
		for (int i = 0; i < 3; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge24 = m;
	endfunction

	// Address decode used by read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == IDX_MOD_CTRL) || (a == IDX_SYNTH_MAIN) || (a == IDX_SYNTH_AUX) ||
			(a == IDX_DAC) || (a == IDX_TARI) || (a == IDX_STATUS);
	endfunction

	// Every access answers one cycle after it is seen
	// A write lands at the edge where waitrequest is low, the only edge the master commits to
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign wr_hit = avs_write && ack_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read || avs_write) && !ack_r;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mod_ctrl_r <= RST_MOD_CTRL;
		end else if (preset) begin
			mod_ctrl_r <= RST_MOD_CTRL;
		end else if (wr_hit && avs_address == IDX_MOD_CTRL) begin
			mod_ctrl_r <= merge24(mod_ctrl_r, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			synth_main_r <= RST_SYNTH_MAIN;
		end else if (preset) begin
			synth_main_r <= RST_SYNTH_MAIN;
		end else if (wr_hit && avs_address == IDX_SYNTH_MAIN) begin
			synth_main_r <= merge24(synth_main_r, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			synth_aux_r <= RST_SYNTH_AUX;
		end else if (preset) begin
			synth_aux_r <= RST_SYNTH_AUX;
		end else if (wr_hit && avs_address == IDX_SYNTH_AUX) begin
			synth_aux_r <= merge24(synth_aux_r, avs_writedata, avs_byteenable);
		end
	end

	// DAC hold
	// No preset is given for this value, so it keeps its contents while disabled
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dac_r <= RST_DAC;
		end else if (wr_hit && avs_address == IDX_DAC && avs_byteenable[0]) begin
			dac_r <= avs_writedata[7:0];
		end
	end

	// Tari selection feeds the delimiter choice
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tari_r <= RST_TARI;
		end else if (preset) begin
			tari_r <= RST_TARI;
		end else if (wr_hit && avs_address == IDX_TARI && avs_byteenable[0]) begin
			tari_r <= avs_writedata[1:0];
		end
	end

	// Read mux and response; unmapped reads zero with slave error
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h00000000;
			resp_r <= 2'h0;
		end else if ((avs_read || avs_write) && !ack_r) begin
			resp_r <= is_mapped(avs_address) ? 2'h0 : 2'h2;
			case (avs_address)
				IDX_MOD_CTRL: rdata_r <= {8'h00, mod_ctrl_r};
				IDX_SYNTH_MAIN: rdata_r <= {8'h00, synth_main_r};
				IDX_SYNTH_AUX: rdata_r <= {8'h00, synth_aux_r};
				IDX_DAC: rdata_r <= {24'h000000, dac_r};
				IDX_TARI: rdata_r <= {30'h00000000, tari_r};
				IDX_STATUS: rdata_r <= {31'h00000000, en_stable_r};
				default: rdata_r <= 32'h00000000;
			endcase
		end
	end
	assign avs_readdata = rdata_r;
	assign avs_response = resp_r;

	assign linear_transient = mod_ctrl_r[MOD_LIN];
	assign phase_reversal_enable = mod_ctrl_r[MOD_PR];
	assign full_depth_ask = mod_ctrl_r[MOD_FULL];
	assign ask_rate = mod_ctrl_r[MOD_ASKRATE_LSB +: 2];

	// Delimiter shape and depth interpretation
	always_comb begin
		shape_t s;
		s = SHAPE_SHAPED;
		if (mod_ctrl_r[MOD_LIN]) begin
			s = SHAPE_LINEAR;
		end else if (mod_ctrl_r[MOD_PR]) begin
			if (tari_r == TARI_12P5 || tari_r == TARI_6P25) begin
				s = SHAPE_ASK_DELIM;
			end else if (mod_ctrl_r[MOD_FULL]) begin
				s = SHAPE_ASK_DELIM;
			end else begin
				s = SHAPE_PR_DELIM;
			end
		end
		delim_shape = s;
	end

	always_comb begin
		if (mod_ctrl_r[MOD_PR] || mod_ctrl_r[MOD_FULL]) begin
			ask_depth = mod_ctrl_r[MOD_FULL] ? DEPTH_FULL : 6'h00;
			// Code 0 is the shortest delimiter, one tenth of a microsecond per step
			delim_tenths_us = 8'(DELIM_MIN_TENTHS) + {2'b00, mod_ctrl_r[MOD_DEP_LSB +: 6]};
		end else begin
			ask_depth = mod_ctrl_r[MOD_DEP_LSB +: 6];
			delim_tenths_us = 8'h00;
		end
	end

	assign ramp_sel = mod_ctrl_r[MOD_RAMP_LSB +: 2];
	always_comb begin
		case (ramp_sel)
			2'h1: ramp_cycles = 16'(RAMP_CYC_1);
			2'h2: ramp_cycles = 16'(RAMP_CYC_2);
			2'h3: ramp_cycles = 16'(RAMP_CYC_3);
			default: ramp_cycles = 16'h0000;
		endcase
	end

	assign coarse_atten = mod_ctrl_r[MOD_COARSE_LSB +: 2];
	assign fine_atten_db = mod_ctrl_r[2:0];

	assign reference_divider_sel = synth_main_r[DIV_REF_LSB +: 3];
	assign ref_freq_khz = ref_khz(reference_divider_sel);

	assign ext_rf_sel = synth_aux_r[AUX_EXT];
	assign osc_direct = synth_aux_r[AUX_DIRECT];
	assign presc_enable = synth_aux_r[AUX_PRESC];
	assign amp_bias_double = synth_main_r[DIV_BIAS];
	assign amp_bias_quad = synth_aux_r[DIV_BIAS];
	assign dac_value = dac_r;

	dual_mod_divider u_main (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.word(synth_main_r),
		.ratio(main_ratio)
	);
	dual_mod_divider u_aux (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.word(synth_aux_r),
		.ratio(aux_ratio)
	);


	// Ramp and delimiter figures must fit their output widths
	if (RAMP_CYC_3 > 32'h0000FFFF) begin : g_ramp_fit
		$error("ramp cycle count too wide for its output");
	end
	if (DELIM_MIN_TENTHS + 63 > 32'h000000FF) begin : g_delim_fit
		$error("delimiter range too wide for its output");
	end

	// Bus handshake in two steps: a fresh request, then the answer one cycle on
	sequence s_req_fresh;
		(avs_read || avs_write) && !ack_r;
	endsequence
	sequence s_req_done;
		!avs_waitrequest;
	endsequence

	// Checks run on the synchronised reset, so they stay quiet while it is released
	// preset while disabled
	a_mod_preset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		preset |=> mod_ctrl_r == RST_MOD_CTRL)
		else $error("modulator word not preset");
	a_main_preset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		preset |=> synth_main_r == RST_SYNTH_MAIN)
		else $error("main divider not preset");
	a_aux_preset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		preset |=> synth_aux_r == RST_SYNTH_AUX)
		else $error("aux divider not preset");
	a_fast_tari: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!linear_transient && phase_reversal_enable && tari_r != TARI_25 && tari_r != 2'h3)
		|-> delim_shape == SHAPE_ASK_DELIM)
		else $error("fast Tari must use ASK delimiter");
	a_slow_tari: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!linear_transient && phase_reversal_enable && tari_r == TARI_25)
		|-> delim_shape == (full_depth_ask ? SHAPE_ASK_DELIM : SHAPE_PR_DELIM))
		else $error("Tari 25 delimiter shape wrong");
	a_full_depth: assert property (@(posedge clk_sys) disable iff (!rst_n)
		full_depth_ask |-> ask_depth == 6'h3F)
		else $error("full depth not forced");
	a_dac_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(wr_hit && avs_address == IDX_DAC) |=> $stable(dac_value))
		else $error("DAC value changed without write");
	a_dac_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_write && !avs_waitrequest && avs_address == IDX_DAC && avs_byteenable[0])
		|=> dac_value == $past(avs_writedata[7:0]))
		else $error("DAC write did not land");
	a_ramp_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ramp_sel == 2'h3 |-> ramp_cycles == 16'hC350)
		else $error("ramp count wrong");
	a_linear_shape: assert property (@(posedge clk_sys) disable iff (!rst_n)
		linear_transient |-> delim_shape == SHAPE_LINEAR)
		else $error("linear transient not selected");
	a_shaped_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!linear_transient && !phase_reversal_enable) |-> delim_shape == SHAPE_SHAPED)
		else $error("shaped transient not selected");
	a_ask_depth: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!phase_reversal_enable && !full_depth_ask) |-> ask_depth == mod_ctrl_r[MOD_DEP_LSB +: 6])
		else $error("ASK depth not taken from field");
	a_delim_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
		((phase_reversal_enable || full_depth_ask) && mod_ctrl_r[MOD_DEP_LSB +: 6] == 6'h1D)
		|-> delim_tenths_us == 8'h7D)
		else $error("delimiter length for code 1D wrong");
	a_ref_200k: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reference_divider_sel == 3'h4 |-> ref_freq_khz == 10'h0C8)
		else $error("reference frequency for code 4 wrong");
	// Bus answer follows a read in the next cycle
	a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest) |=> (avs_read ? !avs_waitrequest : 1'b1))
		else $error("bus answer late");
	// Exactly one wait cycle for every fresh request
	a_one_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_req_fresh |=> s_req_done)
		else $error("bus answer not one cycle after request");
endmodule

// File: dv/tx_synth_cfg_regs_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the transmitter configuration bank.
// Assumes one 125 MHz clock and an Avalon-MM slave that inserts its own wait states.
module tx_synth_cfg_regs_tb
	import txcfg_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic chip_en = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] avs_response;
	logic linear_transient, phase_reversal_enable, full_depth_ask, ext_rf_sel, osc_direct, presc_enable;
	logic amp_bias_double, amp_bias_quad;
	logic [1:0] delim_shape, ask_rate, ramp_sel, coarse_atten;
	logic [5:0] ask_depth;
	logic [7:0] delim_tenths_us;
	logic [15:0] ramp_cycles, main_ratio, aux_ratio;
	logic [2:0] fine_atten_db, reference_divider_sel;
	logic [9:0] ref_freq_khz;
	logic [7:0] dac_value;
	logic [31:0] rd;
	logic [1:0] rsp;
	int errors = 0;
	int checks_done = 0;

	tx_synth_cfg_regs i_tx_synth_cfg_regs (.clk_sys(clk_sys), .rstn(rstn), .chip_en(chip_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .linear_transient(linear_transient),
		.phase_reversal_enable(phase_reversal_enable), .full_depth_ask(full_depth_ask),
		.delim_shape(delim_shape), .ask_depth(ask_depth), .delim_tenths_us(delim_tenths_us), .ask_rate(ask_rate),
		.ramp_sel(ramp_sel), .ramp_cycles(ramp_cycles), .coarse_atten(coarse_atten),
		.fine_atten_db(fine_atten_db), .ref_freq_khz(ref_freq_khz), .reference_divider_sel(reference_divider_sel),
		.main_ratio(main_ratio), .aux_ratio(aux_ratio), .ext_rf_sel(ext_rf_sel), .osc_direct(osc_direct),
		.presc_enable(presc_enable), .amp_bias_double(amp_bias_double), .amp_bias_quad(amp_bias_quad),
		.dac_value(dac_value));

	// Free-running system clock, 8 ns period
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rsp(input logic [1:0] exp);
		chk({30'h0, rsp}, {30'h0, exp});
	endtask

	// One transfer: request held until waitrequest is sampled low at a rising edge, data taken there
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			give_verdict();
		end else begin
			rd = avs_readdata;
			rsp = avs_response;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			// Two edges let registered outputs such as the divide ratios follow the write
			repeat (2) @(posedge clk_sys);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(rd, exp);
	endtask

	// Presets after power-on reset
	task automatic test_reset();
		rd_chk(IDX_MOD_CTRL, 32'h00203F00);
		rd_chk(IDX_SYNTH_MAIN, 32'h0040D84F);
		rd_chk(IDX_SYNTH_AUX, 32'h00011846);
		chk({19'h0, reference_divider_sel, ref_freq_khz}, {19'h0, 3'h4, 10'h0C8});
		chk({main_ratio, aux_ratio}, {16'h10EF, 16'h11C6});
		chk({linear_transient, phase_reversal_enable, full_depth_ask, ask_depth}, {3'h0, 6'h3F});
	endtask

	// Every reference code except 3, bias doubling and the divide ratio
	task automatic test_main();
		int kz[8] = '{500, 250, 125, 0, 200, 100, 50, 25};
		logic [2:0] s;
		for (int i = 0; i < 8; i++) begin
			s = i[2:0];
			if (i != 3) begin
				bus(1'b1, IDX_SYNTH_MAIN, {8'h0, s[0], s, 10'd5, 10'd3}, 4'hF);
				chk({amp_bias_double, reference_divider_sel, ref_freq_khz, main_ratio},
					{s[0], s, kz[i][9:0], 16'h0103});
			end
		end
		bus(1'b1, IDX_SYNTH_MAIN, 32'h0040D84F, 4'hF);
		bus(1'b1, IDX_SYNTH_MAIN, 32'hFFFF00AA, 4'h1);
		bus(1'b1, IDX_SYNTH_MAIN, 32'hFFFFFFFF, 4'h8);
		rd_chk(IDX_SYNTH_MAIN, 32'h0040D8AA);
	endtask

	// Auxiliary control bits in two opposite patterns
	task automatic test_aux();
		bus(1'b1, IDX_SYNTH_AUX, {8'h0, 4'hA, 10'd100, 10'd2}, 4'hF);
		chk({amp_bias_quad, osc_direct, ext_rf_sel, presc_enable, aux_ratio}, {4'hA, 16'd3266});
		bus(1'b1, IDX_SYNTH_AUX, {8'h0, 4'h5, 10'd0, 10'd1023}, 4'hF);
		chk({amp_bias_quad, osc_direct, ext_rf_sel, presc_enable, aux_ratio}, {4'h5, 16'd33759});
	endtask

	task automatic mod_case(input logic [23:0] w, input logic [1:0] t, input logic [18:0] e);
		bus(1'b1, IDX_TARI, {30'h0, t}, 4'hF);
		bus(1'b1, IDX_MOD_CTRL, {8'h0, w}, 4'hF);
		chk({13'h0, linear_transient, phase_reversal_enable, full_depth_ask, delim_shape, ask_depth,
			delim_tenths_us}, {13'h0, e});
	endtask

	// Transient shape, depth and delimiter length decoding
	task automatic test_mod();
		mod_case(24'h008000, TARI_25, {3'h4, 2'h1, 6'h00, 8'h00});
		mod_case(24'h002A00, TARI_25, {3'h0, 2'h0, 6'h2A, 8'h00});
		mod_case(24'h005D00, TARI_25, {3'h2, 2'h3, 6'h00, 8'h7D});
		mod_case(24'h004020, TARI_25, {3'h3, 2'h2, 6'h3F, 8'h60});
		mod_case(24'h007F00, TARI_12P5, {3'h2, 2'h2, 6'h00, 8'h9F});
		mod_case(24'h007F00, TARI_6P25, {3'h2, 2'h2, 6'h00, 8'h9F});
		rd_chk(IDX_TARI, 32'h00000002);
		mod_case(24'h001D20, TARI_25, {3'h1, 2'h0, 6'h3F, 8'h7D});
	endtask

	// Ramp, transient rate and attenuation codes
	task automatic test_level();
		int rc[4] = '{0, 12500, 25000, 50000};
		logic [1:0] c;
		logic [2:0] f;
		for (int i = 0; i < 4; i++) begin
			c = (i > 2) ? 2'h2 : i[1:0];
			f = 3'd7 - i[2:0];
			bus(1'b1, IDX_MOD_CTRL, {14'h0, i[1:0], 8'h10, i[1:0], 1'b0, c, f}, 4'hF);
			chk({7'h0, ask_rate, ramp_sel, ramp_cycles, coarse_atten, f},
				{7'h0, i[1:0], i[1:0], rc[i][15:0], c, f});
			chk({29'h0, fine_atten_db}, {29'h0, f});
		end
	endtask

	// Converter value holds over other traffic; unmapped index refused
	task automatic test_dac();
		bus(1'b1, IDX_DAC, 32'h000000A5, 4'h1);
		chk_rsp(2'h0);
		bus(1'b1, 8'h30, 32'h00000011, 4'hF);
		chk_rsp(2'h2);
		bus(1'b0, 8'h30, 32'h0, 4'hF);
		chk_rsp(2'h2);
		bus(1'b1, IDX_SYNTH_AUX, 32'h00011846, 4'hF);
		chk({24'h0, dac_value}, 32'h000000A5);
		rd_chk(IDX_DAC, 32'h000000A5);
	endtask

	// Chip enable low presets the words; writes meanwhile are lost
	task automatic test_chip_en();
		bus(1'b1, IDX_MOD_CTRL, 32'h00008000, 4'hF);
		chip_en <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk({main_ratio, aux_ratio}, {16'd4335, 16'd4550});
		chk({31'h0, linear_transient}, 32'h0);
		rd_chk(IDX_STATUS, 32'h00000000);
		bus(1'b1, IDX_SYNTH_MAIN, 32'h00000001, 4'hF);
		chip_en <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd_chk(IDX_STATUS, 32'h00000001);
		rd_chk(IDX_MOD_CTRL, 32'h00203F00);
		rd_chk(IDX_SYNTH_MAIN, 32'h0040D84F);
		rd_chk(IDX_SYNTH_AUX, 32'h00011846);
	endtask

	task automatic give_verdict();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence: five cycles of reset, then settle past the enable synchroniser
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (10) @(posedge clk_sys);
		test_reset();
		test_main();
		test_aux();
		test_mod();
		test_level();
		test_dac();
		test_chip_en();
		give_verdict();
	end

	// Whole run needs a few hundred cycles; this cuts a hang short
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule
